// ===== rtl/cep_pick.sv
// fixed-priority picker: lowest set index wins
// assumes: request vector and result are both on the caller's clock
`timescale 1ns/100ps
`default_nettype none
module cep_pick #(
	parameter int N = 22,
	parameter int IW = 5
) (
	// requests
	input wire logic [N-1:0] i_req,
	// result
	output logic o_any,
	output logic [IW-1:0] o_idx
);
	initial begin
		if (N < 1 || N > (1 << IW)) $error("cep_pick: N does not fit IW");
	end

	// scan downward so the lowest index is assigned last
	always_comb begin
		o_any = |i_req;
		o_idx = '1;
		for (int i = N - 1; i >= 0; i--) begin
			if (i_req[i]) o_idx = IW'(i);
		end
	end
endmodule // cep_pick
`default_nettype wire

// ===== rtl/cep_pkg.sv
// package: ranks, cause codes and decode helpers of the exception prioritizer
// assumes: included before every design file that names cep_pkg::
package cep_pkg;

	// number of ranked request slots and the width of a rank index
	localparam int NUM_EXC = 22;
	localparam int RANK_W = 5;
	localparam int CAUSE_W = 5;
	localparam int SW_IRQ_W = 2;
	localparam int COPRO_N = 4;
	localparam int COPRO_W = 2;
	// pin bit positions inside the synchroniser bundle
	localparam int PIN_MASTER_CLEAR_N = 0;
	localparam int PIN_DEBUG_INTERRUPT = 1;
	localparam int PIN_NMI = 2;
	localparam int PIN_W = 3;
	localparam logic [PIN_W-1:0] PIN_INIT = 3'h0;

	// slot 0 is taken first, slot 21 last
	typedef enum logic [RANK_W-1:0] {
		RK_RESET = 5'h00, RK_SSTEP = 5'h01, RK_DBGINT = 5'h02, RK_NMI = 5'h03,
		RK_INT = 5'h04, RK_IBRK = 5'h05, RK_FMIS = 5'h06, RK_FBUS = 5'h07,
		RK_DBGOP = 5'h08, RK_KCALL = 5'h09, RK_SWBRK = 5'h0A, RK_UNDEF = 5'h0B,
		RK_COPRO = 5'h0C, RK_EXTDIS = 5'h0D, RK_WRAP = 5'h0E, RK_TRAP = 5'h0F,
		RK_DSTORE = 5'h10, RK_DLADDR = 5'h11, RK_LMIS = 5'h12, RK_SMIS = 5'h13,
		RK_LSBUS = 5'h14, RK_LDATA = 5'h15, RK_NONE = 5'h1F
	} cep_rank_e;

	// fetch and load address errors share one cause, as do both load breakpoints
	typedef enum logic [CAUSE_W-1:0] {
		CA_NONE = 5'h00, CA_RESET = 5'h01, CA_SSTEP = 5'h02, CA_DBGINT = 5'h03,
		CA_NMI = 5'h04, CA_INT = 5'h05, CA_IBRK = 5'h06, CA_ADDR_LOAD = 5'h07,
		CA_FBUS = 5'h08, CA_DBGOP = 5'h09, CA_KCALL = 5'h0A, CA_SWBRK = 5'h0B,
		CA_UNDEF = 5'h0C, CA_COPRO = 5'h0D, CA_EXTDIS = 5'h0E, CA_WRAP = 5'h0F,
		CA_TRAP = 5'h10, CA_DSTORE = 5'h11, CA_DLOAD = 5'h12, CA_SMIS = 5'h13,
		CA_LSBUS = 5'h14
	} cep_cause_e;

	function automatic cep_cause_e cause_of(input cep_rank_e rk);
		unique case (rk)
			RK_RESET: cause_of = CA_RESET;
			RK_SSTEP: cause_of = CA_SSTEP;
			RK_DBGINT: cause_of = CA_DBGINT;
			RK_NMI: cause_of = CA_NMI;
			RK_INT: cause_of = CA_INT;
			RK_IBRK: cause_of = CA_IBRK;
			RK_FMIS, RK_LMIS: cause_of = CA_ADDR_LOAD;
			RK_FBUS: cause_of = CA_FBUS;
			RK_DBGOP: cause_of = CA_DBGOP;
			RK_KCALL: cause_of = CA_KCALL;
			RK_SWBRK: cause_of = CA_SWBRK;
			RK_UNDEF: cause_of = CA_UNDEF;
			RK_COPRO: cause_of = CA_COPRO;
			RK_EXTDIS: cause_of = CA_EXTDIS;
			RK_WRAP: cause_of = CA_WRAP;
			RK_TRAP: cause_of = CA_TRAP;
			RK_DSTORE: cause_of = CA_DSTORE;
			RK_DLADDR, RK_LDATA: cause_of = CA_DLOAD;
			RK_SMIS: cause_of = CA_SMIS;
			RK_LSBUS: cause_of = CA_LSBUS;
			default: cause_of = CA_NONE;
		endcase
	endfunction

	function automatic logic is_debug(input cep_rank_e rk);
		is_debug = (rk == RK_SSTEP) || (rk == RK_DBGINT) || (rk == RK_IBRK) ||
			(rk == RK_DBGOP) || (rk == RK_DSTORE) || (rk == RK_DLADDR) || (rk == RK_LDATA);
	endfunction

endpackage

// ===== rtl/cep_sync.sv
// two-flop synchroniser for a bundle of pin levels
// assumes: inputs are asynchronous levels held much longer than a clock
`timescale 1ns/100ps
`default_nettype none
module cep_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// pins in, synchronised levels out
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta;

	initial begin
		if (W < 1) $error("cep_sync: W must be at least 1");
	end

	// meta is read by the second stage only
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta <= INIT;
			o_sync <= INIT;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule // cep_sync
`default_nettype wire

// ===== rtl/cep_top.sv
// exception prioritizer of a 32-bit core: gathers reset, debug, nmi,
// interrupt, fetch, execute and load/store conditions and presents one.
// assumes: pipeline condition inputs share i_clk and are held as levels
// until the exception is taken; reset, debug and nmi pins are asynchronous.
//
// Overview of operation
// - master clear or power-on gives reset exception
// - master clear input low resets the device
// - only highest-ranked pending exception is taken
// - single step after each step-mode instruction
// - debug interrupt from pin or break request
// - nmi ranks below debug interrupt
// - unmasked interrupt request raises interrupt exception
// - instruction breakpoint match ranks below interrupts
// - misaligned or protected fetch raises address error
// - fetch bus error ranks below fetch address
// - debug opcode, kernel call, break opcode follow
// - reserved encoding raises undefined opcode exception
// - disabled coprocessor instruction raises unusable exception
// - disabled extension instruction raises its exception
// - arithmetic overflow raises wrap exception
// - trap only when its condition holds
// - data address breakpoints rank above load errors
// - misaligned or protected load raises address error
// - misaligned or protected store raises store error
// - load or store bus error ranks second last
// - load data breakpoint is lowest ranked
`timescale 1ns/100ps
`default_nettype none
module cep_top #(
	parameter int HW_IRQ_W = 6
) (
	// clock and power-on reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// asynchronous pins
	input wire logic i_master_clear_n,
	input wire logic i_debug_interrupt_pin,
	input wire logic i_nmi_pin,
	// debug control from the core side
	input wire logic i_debug_break_request_bit,
	input wire logic i_single_step_en,
	input wire logic i_instr_retire,
	// interrupt controller
	input wire logic [HW_IRQ_W-1:0] i_hw_irq,
	input wire logic [cep_pkg::SW_IRQ_W-1:0] i_sw_irq,
	input wire logic [HW_IRQ_W+cep_pkg::SW_IRQ_W-1:0] i_irq_mask,
	input wire logic i_irq_global_en,
	// fetch stage
	input wire logic i_fetch_valid,
	input wire logic i_ibrk_match,
	input wire logic i_fetch_misalign,
	input wire logic i_fetch_protected,
	input wire logic i_fetch_bus_err,
	// execute stage
	input wire logic i_exec_valid,
	input wire logic i_op_debug_breakpoint,
	input wire logic i_op_kernel_call,
	input wire logic i_op_sw_break,
	input wire logic i_op_reserved,
	input wire logic i_op_copro,
	input wire logic [cep_pkg::COPRO_W-1:0] i_copro_num,
	input wire logic [cep_pkg::COPRO_N-1:0] i_copro_enable,
	input wire logic i_op_ext,
	input wire logic i_ext_enable,
	input wire logic i_arith_overflow,
	input wire logic i_op_trap,
	input wire logic i_trap_cond,
	// load/store stage
	input wire logic i_mem_valid,
	input wire logic i_mem_store,
	input wire logic i_dbrk_addr_match,
	input wire logic i_mem_misalign,
	input wire logic i_mem_protected,
	input wire logic i_mem_bus_err,
	input wire logic i_dbrk_load_data_match,
	// acknowledge from the pipeline
	input wire logic i_exc_taken,
	// presented exception
	output logic o_exc_valid,
	output cep_pkg::cep_rank_e o_exc_rank,
	output cep_pkg::cep_cause_e o_exc_cause,
	output logic o_exc_debug,
	output logic [cep_pkg::NUM_EXC-1:0] o_pending,
	output logic o_core_reset_n
);
	localparam int IRQ_W = HW_IRQ_W + cep_pkg::SW_IRQ_W;

	// the debug interrupt and nmi sticky sources fire on the sampled rising edge only
	function automatic logic rose_now(input logic now, input logic was);
		rose_now = now && !was;
	endfunction

	// a presented rank is consumed when the pipeline acknowledges it
	function automatic logic taking(input logic ack, input logic shown,
		input cep_pkg::cep_rank_e at, input cep_pkg::cep_rank_e want);
		taking = ack && shown && (at == want);
	endfunction

	// misaligned and protected accesses raise the same address error
	function automatic logic addr_bad(input logic mis, input logic prot);
		addr_bad = mis || prot;
	endfunction

	logic [cep_pkg::PIN_W-1:0] pins_raw;
	logic [cep_pkg::PIN_W-1:0] pins_s;
	logic master_clear_n_n_s;
	logic debug_interrupt_pin_s;
	logic nmi_pin_s;
	logic debug_interrupt_pin_d;
	logic nmi_pin_d;
	logic brk_req_d;
	logic in_reset;
	logic sstep_pend;
	logic debug_interrupt_pend;
	logic nmi_pend;
	logic take_sstep;
	logic take_debug_interrupt;
	logic take_nmi;
	logic sstep_eff;
	logic debug_interrupt_eff;
	logic nmi_eff;
	logic irq_any;
	logic [IRQ_W-1:0] irq_hit;
	logic fetch_addr_bad;
	logic mem_addr_bad;
	logic f_ok;
	logic x_ok;
	logic m_load;
	logic m_store;
	logic copro_off;
	logic [cep_pkg::NUM_EXC-1:0] req;
	logic pick_any;
	logic [cep_pkg::RANK_W-1:0] pick_idx;
	cep_pkg::cep_rank_e next_rank;

	initial begin
		if (HW_IRQ_W < 1) $error("cep_top: HW_IRQ_W must be at least 1");
		if (cep_pkg::COPRO_N != (1 << cep_pkg::COPRO_W)) $error("cep_top: copro width");
		if (cep_pkg::NUM_EXC != int'(cep_pkg::RK_LDATA) + 1) $error("cep_top: rank count");
		if (cep_pkg::NUM_EXC > (1 << cep_pkg::RANK_W)) $error("cep_top: rank width");
		if (cep_pkg::PIN_NMI >= cep_pkg::PIN_W) $error("cep_top: pin bundle width");
	end

	// pins cross into i_clk before anything looks at them
	assign pins_raw[cep_pkg::PIN_MASTER_CLEAR_N] = i_master_clear_n;
	assign pins_raw[cep_pkg::PIN_DEBUG_INTERRUPT] = i_debug_interrupt_pin;
	assign pins_raw[cep_pkg::PIN_NMI] = i_nmi_pin;

	cep_sync #(
		.W(cep_pkg::PIN_W),
		.INIT(cep_pkg::PIN_INIT)
	) u_sync (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_async(pins_raw),
		.o_sync(pins_s)
	);

	assign master_clear_n_n_s = pins_s[cep_pkg::PIN_MASTER_CLEAR_N];
	assign debug_interrupt_pin_s = pins_s[cep_pkg::PIN_DEBUG_INTERRUPT];
	assign nmi_pin_s = pins_s[cep_pkg::PIN_NMI];

	// master clear starts synchronised low, so power-on also shows as reset
	assign in_reset = !master_clear_n_n_s;

	// device-wide reset out, low while master clear is held
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_core_reset_n <= 1'b0;
		end else begin
			o_core_reset_n <= master_clear_n_n_s;
		end
	end

	// previous values for edge detection of the event sources
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			debug_interrupt_pin_d <= 1'b0;
			nmi_pin_d <= 1'b0;
			brk_req_d <= 1'b0;
		end else begin
			debug_interrupt_pin_d <= debug_interrupt_pin_s;
			nmi_pin_d <= nmi_pin_s;
			brk_req_d <= i_debug_break_request_bit;
		end
	end

	// a sticky event is consumed only when its own rank is taken
	assign take_sstep = taking(i_exc_taken, o_exc_valid, o_exc_rank, cep_pkg::RK_SSTEP);
	assign take_debug_interrupt = taking(i_exc_taken, o_exc_valid, o_exc_rank, cep_pkg::RK_DBGINT);
	assign take_nmi = taking(i_exc_taken, o_exc_valid, o_exc_rank, cep_pkg::RK_NMI);

	// single step: armed by every retired instruction while stepping
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sstep_pend <= 1'b0;
		end else if (in_reset) begin
			sstep_pend <= 1'b0;
		end else if (i_single_step_en && i_instr_retire) begin
			sstep_pend <= 1'b1;
		end else if (take_sstep) begin
			sstep_pend <= 1'b0;
		end
	end

	// debug interrupt: rising pin or rising break request bit; set beats clear
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			debug_interrupt_pend <= 1'b0;
		end else if (in_reset) begin
			debug_interrupt_pend <= 1'b0;
		end else if (rose_now(debug_interrupt_pin_s, debug_interrupt_pin_d) ||
			rose_now(i_debug_break_request_bit, brk_req_d)) begin
			debug_interrupt_pend <= 1'b1;
		end else if (take_debug_interrupt) begin
			debug_interrupt_pend <= 1'b0;
		end
	end

	// nmi is edge-caught so a short pulse is not lost behind debug events
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			nmi_pend <= 1'b0;
		end else if (in_reset) begin
			nmi_pend <= 1'b0;
		end else if (rose_now(nmi_pin_s, nmi_pin_d)) begin
			nmi_pend <= 1'b1;
		end else if (take_nmi) begin
			nmi_pend <= 1'b0;
		end
	end

	// hide a flag in the cycle it is being consumed, else it shows twice
	assign sstep_eff = sstep_pend && !take_sstep;
	assign debug_interrupt_eff = debug_interrupt_pend && !take_debug_interrupt;
	assign nmi_eff = nmi_pend && !take_nmi;

	// interrupts are levels owned by the controller; no latching here
	assign irq_hit = {i_sw_irq, i_hw_irq} & i_irq_mask;
	assign irq_any = i_irq_global_en && |irq_hit;

	// stage qualifiers
	assign f_ok = i_fetch_valid;
	assign x_ok = i_exec_valid;
	assign m_load = i_mem_valid && !i_mem_store;
	assign m_store = i_mem_valid && i_mem_store;
	assign copro_off = !i_copro_enable[i_copro_num];
	// fetch and data sides keep separate address checks
	assign fetch_addr_bad = addr_bad(i_fetch_misalign, i_fetch_protected);
	assign mem_addr_bad = addr_bad(i_mem_misalign, i_mem_protected);

	// request vector, one slot per rank
	always_comb begin
		req = '0;
		req[cep_pkg::RK_RESET] = in_reset;
		req[cep_pkg::RK_SSTEP] = sstep_eff;
		req[cep_pkg::RK_DBGINT] = debug_interrupt_eff;
		req[cep_pkg::RK_NMI] = nmi_eff;
		req[cep_pkg::RK_INT] = irq_any;
		req[cep_pkg::RK_IBRK] = f_ok && i_ibrk_match;
		req[cep_pkg::RK_FMIS] = f_ok && fetch_addr_bad;
		req[cep_pkg::RK_FBUS] = f_ok && i_fetch_bus_err;
		req[cep_pkg::RK_DBGOP] = x_ok && i_op_debug_breakpoint;
		req[cep_pkg::RK_KCALL] = x_ok && i_op_kernel_call;
		req[cep_pkg::RK_SWBRK] = x_ok && i_op_sw_break;
		req[cep_pkg::RK_UNDEF] = x_ok && i_op_reserved;
		req[cep_pkg::RK_COPRO] = x_ok && i_op_copro && copro_off;
		req[cep_pkg::RK_EXTDIS] = x_ok && i_op_ext && !i_ext_enable;
		req[cep_pkg::RK_WRAP] = x_ok && i_arith_overflow;
		req[cep_pkg::RK_TRAP] = x_ok && i_op_trap && i_trap_cond;
		// an access is either a load or a store, so these two never collide
		req[cep_pkg::RK_DSTORE] = m_store && i_dbrk_addr_match;
		req[cep_pkg::RK_DLADDR] = m_load && i_dbrk_addr_match;
		req[cep_pkg::RK_LMIS] = m_load && mem_addr_bad;
		req[cep_pkg::RK_SMIS] = m_store && mem_addr_bad;
		req[cep_pkg::RK_LSBUS] = i_mem_valid && i_mem_bus_err;
		req[cep_pkg::RK_LDATA] = m_load && i_dbrk_load_data_match;
	end

	cep_pick #(
		.N(cep_pkg::NUM_EXC),
		.IW(cep_pkg::RANK_W)
	) u_pick (
		.i_req(req),
		.o_any(pick_any),
		.o_idx(pick_idx)
	);

	// only the winner goes out; the rest stay pending at their source
	always_comb begin
		if (pick_any) begin
			next_rank = cep_pkg::cep_rank_e'(pick_idx);
		end else begin
			next_rank = cep_pkg::RK_NONE;
		end
	end

	// presented exception, registered; reset shows from power-on onward
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_exc_valid <= 1'b1;
			o_exc_rank <= cep_pkg::RK_RESET;
			o_exc_cause <= cep_pkg::CA_RESET;
			o_exc_debug <= 1'b0;
		end else begin
			o_exc_valid <= pick_any;
			o_exc_rank <= next_rank;
			o_exc_cause <= cep_pkg::cause_of(next_rank);
			o_exc_debug <= cep_pkg::is_debug(next_rank);
		end
	end

	// snapshot of every raised condition, for observation
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_pending <= '0;
		end else begin
			o_pending <= req;
		end
	end
endmodule // cep_top
`default_nettype wire

// ===== verif/cep_pipe_model.sv
// partner: pipeline side that accepts a presented exception
// assumes: clock of cep_top, bench steers enable and delay
`timescale 1ns/100ps
`default_nettype none
module cep_pipe_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// bench control
	input wire logic i_en,
	input wire logic [3:0] i_dly,
	// exception handshake
	input wire logic i_exc_valid,
	output logic o_taken
);
	logic [3:0] seen;
	// one pulse per presentation; saturating count keeps slow mode bounded
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			seen <= 4'h0;
			o_taken <= 1'b0;
		end else begin
			o_taken <= i_en && i_exc_valid && !o_taken && seen >= i_dly;
			seen <= (i_exc_valid && !o_taken) ? seen + {3'h0, seen != 4'hF} : 4'h0;
		end
	end
endmodule // cep_pipe_model
`default_nettype wire

// ===== verif/cep_top_props.sv
// checker: timing and ranking relations at cep_top ports
// assumes: bound onto cep_top, one clock domain
`timescale 1ns/100ps
`default_nettype none
module cep_top_props (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// watched inputs
	input wire logic i_master_clear_n,
	input wire logic i_debug_break_request_bit,
	input wire logic i_nmi_pin,
	input wire logic i_single_step_en,
	input wire logic i_instr_retire,
	input wire logic i_exec_valid,
	input wire logic i_op_trap,
	input wire logic i_trap_cond,
	input wire logic i_exc_taken,
	// watched outputs
	input wire logic o_exc_valid,
	input var cep_pkg::cep_rank_e o_exc_rank,
	input var cep_pkg::cep_cause_e o_exc_cause,
	input wire logic [cep_pkg::NUM_EXC-1:0] o_pending,
	input wire logic o_core_reset_n
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	sequence s_clear;
		!i_master_clear_n [*3];
	endsequence
	sequence s_step;
		i_single_step_en && i_instr_retire && o_core_reset_n;
	endsequence
	AST_CLEAR: assert property (s_clear |=> !o_core_reset_n && o_exc_rank == 5'h00)
		else $error("master clear not presented");
	// a taken sticky flag may still sit in the pending copy
	AST_PICK: assert property (o_exc_valid && !$past(i_exc_taken) |->
		(o_pending & ((22'h1 << o_exc_rank) - 22'h1)) == 22'h0)
		else $error("a higher rank was passed over");
	AST_EMPTY: assert property (!o_exc_valid && !$past(i_exc_taken) |->
		o_pending == 22'h0 && o_exc_rank == 5'h1F && o_exc_cause == 5'h00)
		else $error("idle output not clean");
	AST_TRAP: assert property (i_exec_valid && i_op_trap && o_core_reset_n |=>
		!o_core_reset_n || o_pending[15] == $past(i_trap_cond))
		else $error("trap request does not follow its condition");
	AST_STEP: assert property (s_step |-> ##2 o_pending[1])
		else $error("single step not raised");
	AST_BREAK: assert property ($rose(i_debug_break_request_bit) && o_core_reset_n
		|-> ##[1:3] o_pending[2])
		else $error("break request not raised");
	AST_NMI: assert property ($rose(i_nmi_pin) && o_core_reset_n |-> ##[2:5] o_pending[3])
		else $error("nmi not raised");
	AST_ADDR: assert property (o_exc_rank inside {5'h06, 5'h12} |-> o_exc_cause == 5'h07)
		else $error("address error cause wrong");
endmodule // cep_top_props
`default_nettype wire

// ===== verif/cep_top_test.sv
// testbench: random and corner exception mixes into cep_top
// assumes: cep_pkg, cep_top, partner and checker compiled first
`timescale 1ns/100ps
`default_nettype none
module cep_top_test;
	localparam logic [4:0] CT [22] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
		5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h07, 5'h13, 5'h14, 5'h12};
	logic i_clk, i_rstn, i_master_clear_n, i_debug_interrupt_pin, i_nmi_pin, i_irq_global_en;
	logic i_debug_break_request_bit, i_single_step_en, i_instr_retire, i_exc_taken, part_en;
	logic i_fetch_valid, i_ibrk_match, i_fetch_misalign, i_fetch_protected, i_fetch_bus_err;
	logic i_exec_valid, i_op_debug_breakpoint, i_op_kernel_call, i_op_sw_break, i_op_reserved;
	logic i_op_copro, i_op_ext, i_ext_enable, i_arith_overflow, i_op_trap, i_trap_cond;
	logic i_mem_valid, i_mem_store, i_dbrk_addr_match, i_mem_misalign, i_mem_protected;
	logic i_mem_bus_err, i_dbrk_load_data_match, o_exc_valid, o_exc_debug, o_core_reset_n;
	logic [5:0] i_hw_irq;
	logic [1:0] i_sw_irq, i_copro_num;
	logic [7:0] i_irq_mask;
	logic [3:0] i_copro_enable, part_dly;
	logic [21:0] o_pending, r;
	cep_pkg::cep_rank_e o_exc_rank;
	cep_pkg::cep_cause_e o_exc_cause;
	int miscompares = 0;
	int checks = 0;
	cep_top dut_u (.i_clk, .i_rstn, .i_master_clear_n, .i_debug_interrupt_pin, .i_nmi_pin,
		.i_debug_break_request_bit, .i_single_step_en, .i_instr_retire, .i_hw_irq, .i_sw_irq,
		.i_irq_mask, .i_irq_global_en, .i_fetch_valid, .i_ibrk_match, .i_fetch_misalign,
		.i_fetch_protected, .i_fetch_bus_err, .i_exec_valid, .i_op_debug_breakpoint,
		.i_op_kernel_call, .i_op_sw_break, .i_op_reserved, .i_op_copro, .i_copro_num,
		.i_copro_enable, .i_op_ext, .i_ext_enable, .i_arith_overflow, .i_op_trap, .i_trap_cond,
		.i_mem_valid, .i_mem_store, .i_dbrk_addr_match, .i_mem_misalign, .i_mem_protected,
		.i_mem_bus_err, .i_dbrk_load_data_match, .i_exc_taken, .o_exc_valid, .o_exc_rank,
		.o_exc_cause, .o_exc_debug, .o_pending, .o_core_reset_n);
	cep_pipe_model part_u (.i_clk, .i_rstn, .i_en(part_en), .i_dly(part_dly),
		.i_exc_valid(o_exc_valid), .o_taken(i_exc_taken));
	always #20 i_clk = ~i_clk;
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	function automatic logic [4:0] top_of(input logic [21:0] v);
		top_of = 5'h1F;
		for (int i = 21; i >= 0; i--)
			if (v[i])
				top_of = 5'(i);
	endfunction
	// debug-class ranks: step, debug int, instr bkpt, debug opcode, data bkpts
	function automatic logic dbg_of(input logic [4:0] t);
		dbg_of = t inside {5'h01, 5'h02, 5'h05, 5'h08, 5'h10, 5'h11, 5'h15};
	endfunction
	// unset slots still get benign look-alikes: masked irq, false trap, enabled units
	task automatic put(input logic [21:0] v, input logic q);
		logic [7:0] m;
		logic g;
		logic [1:0] c;
		m = 8'($urandom);
		g = 1'($urandom);
		c = 2'($urandom);
		i_irq_global_en <= q & (v[4] | g);
		{i_sw_irq, i_hw_irq} <= m | {7'h0, v[4]};
		i_irq_mask <= v[4] ? (m | 8'h01) : (g ? ~m : 8'hFF);
		{i_fetch_valid, i_exec_valid, i_mem_valid} <= {3{q}};
		{i_ibrk_match, i_fetch_bus_err} <= {v[5], v[7]};
		i_fetch_misalign <= v[6] & c[0];
		i_fetch_protected <= v[6] & ~c[0];
		{i_op_reserved, i_op_sw_break, i_op_kernel_call, i_op_debug_breakpoint} <= v[11:8];
		{i_op_copro, i_op_ext, i_op_trap, i_copro_num} <= {3'h7, c};
		i_copro_enable <= v[12] ? ~(4'h1 << c) : 4'hF;
		i_ext_enable <= ~v[13];
		{i_trap_cond, i_arith_overflow} <= v[15:14];
		i_mem_store <= v[16] | v[19];
		i_dbrk_addr_match <= v[16] | v[17];
		i_mem_misalign <= (v[18] | v[19]) & c[1];
		i_mem_protected <= (v[18] | v[19]) & ~c[1];
		{i_dbrk_load_data_match, i_mem_bus_err} <= v[21:20];
	endtask
	task automatic pick(input logic [21:0] v, input logic q);
		logic [4:0] t;
		@(posedge i_clk);
		put(v, q);
		repeat (2) @(posedge i_clk);
		#1;
		t = top_of(q ? v : 22'h0);
		chk("rank", o_exc_rank, t);
		chk("cause", o_exc_cause, t == 5'h1F ? 5'h00 : CT[t]);
		chk("pending", o_pending, q ? v : 22'h0);
		chk("valid", o_exc_valid, t != 5'h1F);
		chk("debug", o_exc_debug, dbg_of(t));
	endtask
	task automatic wait_rank(input logic [4:0] rk);
		// never read the output in the time step of the edge that updates it
		#1;
		for (int n = 0; n < 20 && o_exc_rank !== rk; n++) begin
			@(posedge i_clk);
			#1;
		end
		chk("wait rank", o_exc_rank, rk);
	endtask
	initial begin
		{i_clk, i_rstn, i_debug_interrupt_pin, i_nmi_pin, i_debug_break_request_bit} = 5'h0;
		{i_single_step_en, i_instr_retire, part_en, i_master_clear_n} = 4'h1;
		part_dly = 4'h0;
		void'($urandom(42864));
		put(22'h0, 1'b1);
		repeat (4) @(posedge i_clk);
		#1;
		chk("reset rank", o_exc_rank, 5'h00);
		chk("reset out", o_core_reset_n, 1'b0);
		chk("reset valid", o_exc_valid, 1'b1);
		@(posedge i_clk);
		i_rstn <= 1'b1;
		pick(22'h0, 1'b1);
		chk("reset out", o_core_reset_n, 1'b1);
		$display("test reset done");
		for (int i = 4; i < 22; i++)
			pick(22'h1 << i, 1'b1);
		pick(22'h1BFFF0, 1'b0);
		for (int k = 0; k < 60; k++) begin
			r = 22'($urandom & $urandom) & 22'h3FFFF0;
			r = r & (($urandom % 2) ? ~22'h260000 : ~22'h090000);
			pick(r, 1'b1);
		end
		// drop the last random levels, else they mask the sticky tests
		pick(22'h0, 1'b1);
		$display("test levels done");
		@(posedge i_clk);
		part_en <= 1'b0;
		{i_single_step_en, i_instr_retire, i_debug_break_request_bit} <= 3'h7;
		@(posedge i_clk);
		i_instr_retire <= 1'b0;
		wait_rank(5'h01);
		repeat (3) @(posedge i_clk);
		part_en <= 1'b1;
		part_dly <= 4'h3;
		wait_rank(5'h02);
		wait_rank(5'h1F);
		@(posedge i_clk);
		{i_single_step_en, i_debug_break_request_bit, part_en} <= 3'h0;
		i_nmi_pin <= 1'b1;
		wait_rank(5'h03);
		@(posedge i_clk);
		i_debug_interrupt_pin <= 1'b1;
		wait_rank(5'h02);
		@(posedge i_clk);
		part_en <= 1'b1;
		part_dly <= 4'h0;
		wait_rank(5'h03);
		wait_rank(5'h1F);
		@(posedge i_clk);
		{i_nmi_pin, i_debug_interrupt_pin, part_en} <= 3'h0;
		$display("test sticky done");
		repeat (3) @(posedge i_clk);
		i_nmi_pin <= 1'b1;
		wait_rank(5'h03);
		@(posedge i_clk);
		i_master_clear_n <= 1'b0;
		repeat (4) @(posedge i_clk);
		#1;
		chk("clear rank", o_exc_rank, 5'h00);
		chk("clear cause", o_exc_cause, 5'h01);
		chk("clear out", o_core_reset_n, 1'b0);
		@(posedge i_clk);
		i_master_clear_n <= 1'b1;
		repeat (5) @(posedge i_clk);
		#1;
		chk("flags cleared", o_exc_rank, 5'h1F);
		$display("test clear done");
		complete_run();
	end
	initial begin
		repeat (3000) @(posedge i_clk);
		miscompares++;
		complete_run();
	end
endmodule // cep_top_test
bind cep_top cep_top_props props_u (.i_clk, .i_rstn, .i_master_clear_n, .i_debug_break_request_bit,
	.i_nmi_pin, .i_single_step_en, .i_instr_retire, .i_exec_valid, .i_op_trap, .i_trap_cond,
	.i_exc_taken, .o_exc_valid, .o_exc_rank, .o_exc_cause, .o_pending, .o_core_reset_n);
`default_nettype wire
